/* File: core/bus_txn_pkg.sv */
package bus_txn_pkg;

    // ---------------------------------------------------------------
    // Bus shape
    // ---------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int SEG_W  = 7;
    localparam int ROW_W  = 9;
    localparam int BUF_DEPTH = 2;

    // ---------------------------------------------------------------
    // Cycle counts
    // ---------------------------------------------------------------
    localparam logic [3:0] MEM_CYCLES = 4'h3;
    localparam logic [3:0] IO_CYCLES  = 4'h4;
    localparam logic [3:0] ACK_CYCLES = 4'h8;
    // Strobe-low cycles of the automatic ack waits; the fifth is the first sample cycle
    localparam logic [2:0] ACK_AUTO_LOW = 3'h4;

    // ---------------------------------------------------------------
    // Status codes
    // ---------------------------------------------------------------
    localparam logic [3:0] ST_INTERNAL  = 4'h0;
    localparam logic [3:0] ST_REFRESH   = 4'h1;
    localparam logic [3:0] ST_IO_STD    = 4'h2;
    localparam logic [3:0] ST_IO_SPC    = 4'h3;
    localparam logic [1:0] ST_ACK_HI    = 2'h1;
    localparam logic [3:0] ST_DATA      = 4'h8;
    localparam logic [3:0] ST_STACK     = 4'h9;
    localparam logic [3:0] ST_DATA_EPU  = 4'hA;
    localparam logic [3:0] ST_STACK_EPU = 4'hB;
    localparam logic [3:0] ST_PROG      = 4'hC;
    localparam logic [3:0] ST_PROG_1ST  = 4'hD;
    localparam logic [3:0] ST_EPU_XFER  = 4'hE;

    // Memory space field of the request code
    localparam logic [1:0] SPACE_DATA  = 2'h0;
    localparam logic [1:0] SPACE_STACK = 2'h1;

    // Read lane select
    localparam logic [1:0] LANE_WORD = 2'h0;
    localparam logic [1:0] LANE_LOW  = 2'h1;
    localparam logic [1:0] LANE_HIGH = 2'h2;

    localparam logic [15:0] AD_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        KIND_MEM      = 3'b000,
        KIND_IO       = 3'b001,
        KIND_EPU      = 3'b010,
        KIND_ACK      = 3'b011,
        KIND_INTERNAL = 3'b100,
        KIND_REFRESH  = 3'b101
    } kind_t;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_ADDR   = 3'b001,
        S_PRE    = 3'b010,
        S_AUTO   = 3'b011,
        S_SAMPLE = 3'b100,
        S_WAIT   = 3'b101,
        S_LAST   = 3'b110
    } state_t;

endpackage

/* File: core/cpu_bus_transaction_unit.sv */
`timescale 1ns/1ns
// Summary of operation
// - Memory transaction lasts three cycles plus one per low wait sample.
// - Memory status codes data 1000/1010, stack 1001/1011, program 1100/1101.
// - Opening instruction word fetch drives status 1101.
// - Codes 1010/1011 mean a coprocessor sources or sinks the data.
// - Offset valid on bus at address strobe rise; segment lines change on the same edge as the offset.
// - Odd-address bytes on low lane, even-address bytes on high lane.
// - Byte writes replicated on both halves; byte reads use addressed lane.
// - Word memory transfers use all sixteen data bits.
// - I/O transactions last at least four cycles, stretched by wait.
// - I/O status 0010/0011, mode low, port address on bus.
// - I/O bytes on low lane standard, high lane special; words full width.
// - Coprocessor transfers: three cycles unless waited, no address, status 1110.
// - Coprocessor transfers are words, flags byte on low lane, mode passed.
// - Acknowledge lasts at least eight cycles with five automatic waits.
// - Acknowledge status 0100..0111, no address, mode low, read, word.
// - Acknowledge captures a 16-bit identifier just before strobe rises.
// - Acknowledge samples wait twice: before strobe fall and before data read.
// - Internal and refresh look like memory with data strobe held high.
// - Internal operation: zero address, read, size repeats previous.
// - Refresh may follow at once, puts 9-bit row low, repeats mode/dir/size.
// - Wait is ignored during internal and refresh transactions.
// - Wait sampled one cycle before data sample; each low sample adds a cycle.
module cpu_bus_transaction_unit
    import bus_txn_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire kind_t             req_kind,
    input  wire logic [1:0]        req_code,
    input  wire logic              req_epu,
    input  wire logic              req_first_fetch,
    input  wire logic              req_read,
    input  wire logic              req_byte,
    input  wire logic              req_normal_mode,
    input  wire logic [DATA_W-1:0] req_addr,
    input  wire logic [SEG_W-1:0]  req_segment,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   rsp_valid,
    input  wire logic              rsp_ready,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   address_strobe_n,
    output logic                   data_strobe_n,
    output logic [3:0]             transaction_status,
    output logic                   normal_mode,
    output logic                   read_high,
    output logic                   byte_high,
    output logic [SEG_W-1:0]       segment_number_lines,
    output logic [DATA_W-1:0]      addr_data_out,
    output logic                   addr_data_oe,
    input  wire logic [DATA_W-1:0] addr_data_in,
    input  wire logic              wait_n
);

    function automatic logic [3:0] status_of(kind_t k, logic [1:0] c, logic extended_processing_unit, logic first);
        logic [3:0] s;
        s = ST_INTERNAL;
        unique case (k)
            KIND_MEM: begin
                if (c == SPACE_DATA) begin
                    s = extended_processing_unit ? ST_DATA_EPU : ST_DATA;
                end else if (c == SPACE_STACK) begin
                    s = extended_processing_unit ? ST_STACK_EPU : ST_STACK;
                end else begin
                    s = first ? ST_PROG_1ST : ST_PROG;
                end
            end
            KIND_IO:       s = c[0] ? ST_IO_SPC : ST_IO_STD;
            KIND_EPU:      s = ST_EPU_XFER;
            KIND_ACK:      s = {ST_ACK_HI, c};
            KIND_INTERNAL: s = ST_INTERNAL;
            KIND_REFRESH:  s = ST_REFRESH;
            default:       s = ST_INTERNAL;
        endcase
        return s;
    endfunction

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic              wait_s1_ff, wait_s2_ff;
    logic [DATA_W-1:0] din_s1_ff,  din_s2_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wait_s1_ff <= 1'b1;
            wait_s2_ff <= 1'b1;
            din_s1_ff  <= AD_ZERO;
            din_s2_ff  <= AD_ZERO;
        end else begin
            wait_s1_ff <= wait_n;
            wait_s2_ff <= wait_s1_ff;
            din_s1_ff  <= addr_data_in;
            din_s2_ff  <= din_s1_ff;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    state_t            state_ff, nxt_state;
    kind_t             kind_ff, nxt_kind;
    logic [2:0]        cnt_ff, nxt_cnt;
    logic [3:0]        status_ff, nxt_status;
    logic              mode_ff, nxt_mode, read_ff, nxt_read, byte_ff, nxt_byte;
    logic              sinks_ff, nxt_sinks, drives_ff, nxt_drives, has_addr_ff, nxt_has_addr;
    logic [1:0]        lane_ff, nxt_lane;
    logic [SEG_W-1:0]  seg_ff, nxt_seg;
    logic [DATA_W-1:0] ad_ff, nxt_ad, wdata_ff, nxt_wdata;
    logic [ROW_W-1:0]  row_ff, nxt_row;
    logic [1:0]        pend_ff, nxt_pend;
    logic [1:0]        plane0_ff, plane1_ff, nxt_plane0, nxt_plane1;
    logic [1:0]        count_ff;
    logic              accept, waitable, wait_low, epu_coded, strobe_state;

    assign waitable     = (kind_ff != KIND_INTERNAL) && (kind_ff != KIND_REFRESH);
    assign wait_low     = waitable && !wait_s2_ff;
    assign epu_coded    = req_epu && (req_code[1] == 1'b0);
    assign strobe_state = (state_ff == S_AUTO) || (state_ff == S_SAMPLE)
                        || (state_ff == S_WAIT) || (state_ff == S_LAST);

    // A capturing read is only taken while its word has a buffer slot waiting
    always_comb begin
        logic [2:0] occ;
        logic       new_sinks;
        occ = {1'b0, count_ff} + {2'b00, pend_ff[0]} + {2'b00, pend_ff[1]}
            + {2'b00, (state_ff == S_LAST) && sinks_ff};
        new_sinks = (req_kind == KIND_ACK) || (req_read && ((req_kind == KIND_IO)
                  || (req_kind == KIND_EPU) || (req_kind == KIND_MEM && !epu_coded)));
        req_ready = ((state_ff == S_IDLE) || (state_ff == S_LAST))
                  && (!new_sinks || (occ < 3'(BUF_DEPTH)));
    end
    assign accept = req_valid && req_ready;

    always_comb begin
        nxt_state = state_ff;   nxt_kind = kind_ff;    nxt_cnt = cnt_ff;
        nxt_status = status_ff; nxt_mode = mode_ff;    nxt_read = read_ff;
        nxt_byte = byte_ff;     nxt_sinks = sinks_ff;  nxt_drives = drives_ff;
        nxt_has_addr = has_addr_ff;                    nxt_lane = lane_ff;
        nxt_seg = seg_ff;       nxt_ad = ad_ff;        nxt_wdata = wdata_ff;
        nxt_row = row_ff;
        nxt_pend = {pend_ff[0], (state_ff == S_LAST) && sinks_ff};
        nxt_plane0 = lane_ff;
        nxt_plane1 = plane0_ff;
        unique case (state_ff)
            S_IDLE:   ;
            S_ADDR: begin
                nxt_ad = wdata_ff;
                nxt_cnt = 3'h0;
                if (kind_ff == KIND_IO || kind_ff == KIND_ACK) begin
                    nxt_state = S_PRE;
                end else begin
                    nxt_state = S_SAMPLE;
                end
            end
            S_PRE: begin
                if (kind_ff == KIND_IO) begin
                    nxt_state = S_SAMPLE;
                end else if (!wait_low) begin
                    nxt_state = S_AUTO;
                end
            end
            S_AUTO: begin
                nxt_cnt = cnt_ff + 3'h1;
                if (cnt_ff == ACK_AUTO_LOW - 3'h1) begin
                    nxt_state = S_SAMPLE;
                end
            end
            S_SAMPLE, S_WAIT: nxt_state = wait_low ? S_WAIT : S_LAST;
            S_LAST:   nxt_state = S_IDLE;
            default:  nxt_state = S_IDLE;
        endcase
        if (accept) begin
            nxt_state  = S_ADDR;
            nxt_kind   = req_kind;
            nxt_status = status_of(req_kind, req_code, req_epu, req_first_fetch);
            nxt_seg    = (req_kind == KIND_MEM) ? req_segment : '0;
            nxt_ad     = req_addr;
            nxt_has_addr = (req_kind == KIND_MEM) || (req_kind == KIND_IO)
                         || (req_kind == KIND_REFRESH) || (req_kind == KIND_INTERNAL);
            nxt_wdata  = req_byte ? {req_wdata[7:0], req_wdata[7:0]} : req_wdata;
            nxt_sinks  = (req_kind == KIND_ACK) || (req_read && ((req_kind == KIND_IO)
                       || (req_kind == KIND_EPU) || (req_kind == KIND_MEM && !epu_coded)));
            nxt_drives = !req_read && ((req_kind == KIND_IO) || (req_kind == KIND_EPU)
                       || (req_kind == KIND_MEM && !epu_coded));
            if (!req_byte || req_kind == KIND_ACK) begin
                nxt_lane = LANE_WORD;
            end else if (req_kind == KIND_MEM) begin
                nxt_lane = req_addr[0] ? LANE_LOW : LANE_HIGH;
            end else if (req_kind == KIND_IO) begin
                nxt_lane = req_code[0] ? LANE_HIGH : LANE_LOW;
            end else begin
                nxt_lane = LANE_LOW;
            end
            unique case (req_kind)
                KIND_MEM, KIND_EPU: begin
                    nxt_mode = req_normal_mode;
                    nxt_read = req_read;
                    nxt_byte = req_byte;
                end
                KIND_IO: begin
                    nxt_mode = 1'b0;
                    nxt_read = req_read;
                    nxt_byte = req_byte;
                end
                KIND_ACK: begin
                    nxt_mode = 1'b0;
                    nxt_read = 1'b1;
                    nxt_byte = 1'b0;
                end
                KIND_INTERNAL: begin
                    nxt_mode = req_normal_mode;
                    nxt_read = 1'b1;
                    nxt_ad   = AD_ZERO;
                end
                KIND_REFRESH: begin
                    nxt_ad  = {{(DATA_W-ROW_W){1'b0}}, row_ff};
                    nxt_row = row_ff + 9'h001;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;       kind_ff <= KIND_INTERNAL; cnt_ff <= 3'h0;
            status_ff <= ST_INTERNAL; mode_ff <= 1'b0;          read_ff <= 1'b1;
            byte_ff <= 1'b0;          sinks_ff <= 1'b0;         drives_ff <= 1'b0;
            has_addr_ff <= 1'b0;      lane_ff <= LANE_WORD;     seg_ff <= '0;
            ad_ff <= AD_ZERO;         wdata_ff <= AD_ZERO;      row_ff <= '0;
            pend_ff <= 2'h0;          plane0_ff <= LANE_WORD;   plane1_ff <= LANE_WORD;
        end else begin
            state_ff <= nxt_state;    kind_ff <= nxt_kind;      cnt_ff <= nxt_cnt;
            status_ff <= nxt_status;  mode_ff <= nxt_mode;      read_ff <= nxt_read;
            byte_ff <= nxt_byte;      sinks_ff <= nxt_sinks;    drives_ff <= nxt_drives;
            has_addr_ff <= nxt_has_addr; lane_ff <= nxt_lane;   seg_ff <= nxt_seg;
            ad_ff <= nxt_ad;          wdata_ff <= nxt_wdata;    row_ff <= nxt_row;
            pend_ff <= nxt_pend;      plane0_ff <= nxt_plane0;  plane1_ff <= nxt_plane1;
        end
    end

    assign address_strobe_n     = (state_ff != S_ADDR);
    assign data_strobe_n        = !(strobe_state && waitable);
    assign transaction_status   = status_ff;
    assign normal_mode          = mode_ff;
    assign read_high            = read_ff;
    assign byte_high            = byte_ff;
    assign segment_number_lines = seg_ff;
    assign addr_data_out        = ad_ff;
    // Reads and coprocessor-coded transfers leave the lines to the far side
    assign addr_data_oe = ((state_ff == S_ADDR) && has_addr_ff)
                        || (strobe_state && drives_ff && waitable);

    // ---------------------------------------------------------------
    // Two-entry response buffer
    // ---------------------------------------------------------------
    logic [DATA_W-1:0] buf_ff [BUF_DEPTH], nxt_buf [BUF_DEPTH];
    logic              wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic [1:0]        nxt_count;
    logic [DATA_W-1:0] captured;
    logic              push, pop;

    always_comb begin
        unique case (plane1_ff)
            LANE_LOW:  captured = {8'h00, din_s2_ff[7:0]};
            LANE_HIGH: captured = {8'h00, din_s2_ff[15:8]};
            default:   captured = din_s2_ff;
        endcase
    end

    assign push      = pend_ff[1];
    assign pop       = rsp_valid && rsp_ready;
    assign rsp_valid = (count_ff != 2'h0);
    assign rsp_data  = buf_ff[rd_ptr_ff];

    always_comb begin
        nxt_buf    = buf_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count  = count_ff;
        if (push) begin
            nxt_buf[wr_ptr_ff] = captured;
            nxt_wr_ptr = !wr_ptr_ff;
        end
        if (pop) begin
            nxt_rd_ptr = !rd_ptr_ff;
        end
        nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                buf_ff[i] <= AD_ZERO;
            end
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            buf_ff    <= nxt_buf;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff  <= nxt_count;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [3:0] len_ff, waits_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            len_ff   <= 4'h0;
            waits_ff <= 4'h0;
        end else if (state_ff == S_ADDR) begin
            len_ff   <= 4'h2;
            waits_ff <= 4'h0;
        end else if (state_ff != S_IDLE) begin
            len_ff   <= len_ff + 4'h1;
            waits_ff <= waits_ff + {3'h0, (state_ff == S_WAIT)
                      || (state_ff == S_PRE && kind_ff == KIND_ACK && nxt_state == S_PRE)};
        end
    end

    mem_length_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == S_LAST && (kind_ff == KIND_MEM || kind_ff == KIND_EPU))
        |-> len_ff == MEM_CYCLES + waits_ff) else $error("memory length wrong");
    io_length_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == S_LAST && kind_ff == KIND_IO) |-> len_ff == IO_CYCLES + waits_ff)
        else $error("io length wrong");
    ack_length_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == S_LAST && kind_ff == KIND_ACK) |-> len_ff == ACK_CYCLES + waits_ff)
        else $error("ack length wrong");
    first_fetch_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (accept && req_kind == KIND_MEM && req_code[1] && req_first_fetch)
        |=> transaction_status == ST_PROG_1ST && !address_strobe_n)
        else $error("first fetch code wrong");
    io_mode_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (accept && req_kind == KIND_IO) |=> !normal_mode [*3])
        else $error("io mode not system");
    byte_replicate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (addr_data_oe && !data_strobe_n && byte_high)
        |-> addr_data_out[15:8] == addr_data_out[7:0]) else $error("byte not replicated");
    no_data_strobe_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (accept && (req_kind == KIND_INTERNAL || req_kind == KIND_REFRESH))
        |=> data_strobe_n [*3] ##1 state_ff != S_WAIT) else $error("strobe in idle cycle");
    refresh_row_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (accept && req_kind == KIND_REFRESH) |=> addr_data_oe
        && addr_data_out == {7'h00, $past(row_ff)} && read_high == $past(read_ff))
        else $error("refresh row or repeat wrong");
    epu_no_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == S_ADDR && (kind_ff == KIND_EPU || kind_ff == KIND_ACK))
        |-> !addr_data_oe) else $error("address driven without one");
    epu_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!data_strobe_n && (transaction_status == ST_DATA_EPU
        || transaction_status == ST_STACK_EPU)) |-> !addr_data_oe)
        else $error("bus not floated for coprocessor data");
    ack_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == S_LAST && kind_ff == KIND_ACK) |-> ##2 push)
        else $error("identifier not captured");
    wait_ignored_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == S_LAST && !waitable) |-> waits_ff == 4'h0)
        else $error("wait obeyed in no-data transaction");

endmodule

/* File: verif/bus_partner.sv */
`timescale 1ns/1ns
module bus_partner (
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic        address_strobe_n,
    input  wire logic        data_strobe_n,
    input  wire logic        read_high,
    input  wire logic [15:0] addr_data_out,
    input  wire logic        addr_data_oe,
    output logic      [15:0] addr_data_in,
    output logic             wait_n
);
    logic [15:0] lat_ff  = 16'h0000;
    logic [15:0] idle_ff = 16'h0000;
    logic [3:0]  age_ff  = 4'hF;
    logic [15:0] swp;
    // Slow part holds wait low while idle too: the sync flops see the pin two cycles late
    assign wait_n = !(slow && (age_ff < 4'h4 || age_ff == 4'hF));
    assign swp = {lat_ff[7:0], lat_ff[15:8]};
    // Halves swapped so a wrong lane choice shows; released bus toggles
    assign addr_data_in = (read_high && !data_strobe_n) ? swp ^ 16'h5A3C : idle_ff;
    always @(posedge mclk) begin
        idle_ff <= ~addr_data_in;
        age_ff <= !address_strobe_n ? 4'h0 : age_ff + 4'(age_ff != 4'hF);
        if (!address_strobe_n)
            lat_ff <= addr_data_oe ? addr_data_out : 16'h1357;
    end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import bus_txn_pkg::*;
    logic              mclk, rst_n, req_valid, req_ready, req_epu, req_first_fetch;
    logic              req_read, req_byte, req_normal_mode, rsp_valid, rsp_ready;
    logic              address_strobe_n, data_strobe_n, normal_mode, read_high;
    logic              byte_high, addr_data_oe, wait_n, slow;
    kind_t             req_kind;
    logic [1:0]        req_code;
    logic [2:0]        pins_c, pv;
    logic [3:0]        transaction_status, st_c;
    logic [SEG_W-1:0]  req_segment, segment_number_lines, sg_c;
    logic [15:0]       req_addr, req_wdata, rsp_data, addr_data_out, addr_data_in, ad_c, wd_c;
    int                n_fail = 0, comparisons = 0, cnt = 0, last_ds = 0;

    cpu_bus_transaction_unit cpu_bus_transaction_unit_i (.*);
    bus_partner              bus_partner_i (.*);

    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cnt <= address_strobe_n ? cnt + 1 : 1;
        if (!address_strobe_n) begin
            last_ds <= 0;
            st_c <= transaction_status;
            ad_c <= addr_data_out;
            sg_c <= segment_number_lines;
            pins_c <= {normal_mode, read_high, byte_high};
        end
        if (!data_strobe_n)
            last_ds <= cnt + 1;
        if (!data_strobe_n && addr_data_oe)
            wd_c <= addr_data_out;
    end

    task automatic give_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang(input string nm);
        cmp(nm, 16'h0001, 16'h0000);
        give_verdict;
    endtask
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    function automatic logic [15:0] mv(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ 16'h5A3C;
    endfunction
    function automatic logic [15:0] bl(input logic [15:0] a, input logic hi);
        logic [15:0] m;
        m = mv(a);
        return {8'h00, hi ? m[15:8] : m[7:0]};
    endfunction
    task automatic pop(input logic [15:0] ex);
        for (int i = 0; !rsp_valid; i++) begin
            if (i == 30) hang("rsp_valid");
            tick;
        end
        cmp("read data", ex, rsp_data);
        tick;
    endtask
    // Flags f: epu, first fetch, read, byte, normal mode
    task automatic issue(input kind_t k, input logic [1:0] c, input logic [4:0] f,
                         input logic [15:0] a, w);
        tick;
        {req_epu, req_first_fetch, req_read, req_byte, req_normal_mode} = f;
        req_kind = k;
        {req_code, req_addr, req_wdata} = {c, a, w};
        req_valid = 1;
        for (int i = 0; !req_ready; i++) begin
            if (i == 60) hang("req_ready");
            tick;
        end
        tick;
        req_valid = 0;
    endtask
    task automatic go(input kind_t k, input logic [1:0] c, input logic [4:0] f,
                      input logic [15:0] a, w, ex, input logic [3:0] st, input int len);
        logic [2:0] ep;
        ep = {(k == KIND_IO || k == KIND_ACK) ? 1'b0 : f[0], f[2], f[1]};
        if (k == KIND_REFRESH) ep = pv;
        if (k == KIND_INTERNAL) ep = {f[0], 1'b1, pv[0]};
        issue(k, c, f, a, w);
        tick;
        for (int i = 0; !(req_ready && data_strobe_n); i++) begin
            if (i == 60) hang("end of transaction");
            tick;
        end
        if (slow && len > 0) cmp("stretched", 16'h0001, 16'(last_ds > len));
        else cmp("length", 16'(len), 16'(last_ds));
        cmp("status", 16'(st), 16'(st_c));
        cmp("mode dir size", 16'(ep), 16'(pins_c));
        pv = ep;
        if (k == KIND_MEM || k == KIND_IO) cmp("address", a, ad_c);
        if (k == KIND_MEM) cmp("segment", 16'h0055, 16'(sg_c));
        if (k == KIND_REFRESH) cmp("row", ex, ad_c & 16'h01FF);
        if (!f[2] && !f[4] && k < KIND_ACK) cmp("write data", ex, wd_c);
        if (f[2] && !f[4] && k < KIND_INTERNAL) pop(ex);
    endtask

    task automatic t_mem;
        go(KIND_MEM, 0, 5'h05, 16'h1230, 0, mv(16'h1230), 4'h8, 3);
        go(KIND_MEM, 1, 5'h00, 16'h4442, 16'hBEEF, 16'hBEEF, 4'h9, 3);
        go(KIND_MEM, 2, 5'h05, 16'h0100, 0, mv(16'h0100), 4'hC, 3);
        go(KIND_MEM, 3, 5'h0D, 16'h0102, 0, mv(16'h0102), 4'hD, 3);
        go(KIND_MEM, 0, 5'h07, 16'h2001, 0, bl(16'h2001, 0), 4'h8, 3);
        go(KIND_MEM, 1, 5'h07, 16'h2002, 0, bl(16'h2002, 1), 4'h9, 3);
        go(KIND_MEM, 0, 5'h02, 16'h3002, 16'h00A7, 16'hA7A7, 4'h8, 3);
        go(KIND_MEM, 0, 5'h15, 16'h0300, 0, 0, 4'hA, 3);
        go(KIND_MEM, 1, 5'h10, 16'h0302, 16'h1234, 0, 4'hB, 3);
    endtask
    task automatic t_io;
        go(KIND_IO, 0, 5'h05, 16'h0100, 0, mv(16'h0100), 4'h2, 4);
        go(KIND_IO, 1, 5'h01, 16'h0200, 16'h5AA5, 16'h5AA5, 4'h3, 4);
        go(KIND_IO, 0, 5'h07, 16'h0101, 0, bl(16'h0101, 0), 4'h2, 4);
        go(KIND_IO, 1, 5'h07, 16'h0202, 0, bl(16'h0202, 1), 4'h3, 4);
    endtask
    task automatic t_epu_ack;
        go(KIND_EPU, 0, 5'h05, 0, 0, mv(16'h1357), 4'hE, 3);
        go(KIND_EPU, 0, 5'h07, 0, 0, bl(16'h1357, 0), 4'hE, 3);
        go(KIND_EPU, 0, 5'h00, 0, 16'h1111, 16'h1111, 4'hE, 3);
        for (int c = 0; c < 4; c++)
            go(KIND_ACK, 2'(c), 5'h04, 0, 0, mv(16'h1357), 4'(c + 4), 8);
    endtask
    task automatic t_quiet;
        go(KIND_INTERNAL, 0, 5'h05, 0, 0, 0, 4'h0, 0);
        go(KIND_REFRESH, 0, 5'h00, 0, 0, 16'h0000, 4'h1, 0);
        slow = 1;
        go(KIND_REFRESH, 0, 5'h02, 0, 0, 16'h0001, 4'h1, 0);
        repeat (16) tick;
        go(KIND_MEM, 0, 5'h05, 16'h5550, 0, mv(16'h5550), 4'h8, 3);
        repeat (16) tick;
        go(KIND_IO, 0, 5'h04, 16'h0104, 0, mv(16'h0104), 4'h2, 4);
        repeat (16) tick;
        go(KIND_ACK, 3, 5'h04, 0, 0, mv(16'h1357), 4'h7, 8);
        slow = 0;
    endtask
    // Receiver stalls: the two-entry buffer must refuse a third capture, lose nothing
    task automatic t_stall;
        rsp_ready = 0;
        issue(KIND_MEM, 0, 5'h05, 16'h0010, 0);
        issue(KIND_MEM, 0, 5'h05, 16'h0020, 0);
        repeat (20) tick;
        cmp("refused", 16'h0000, 16'(req_ready));
        rsp_ready = 1;
        pop(mv(16'h0010));
        pop(mv(16'h0020));
        cmp("drained", 16'h0000, 16'(rsp_valid));
    endtask

    initial begin
        {mclk, rst_n, req_valid, slow, req_epu, req_first_fetch} = 0;
        {req_read, req_byte, req_normal_mode, req_code, req_addr, req_wdata} = 0;
        {rsp_ready, req_segment, pv} = {1'b1, 7'h55, 3'h2};
        req_kind = KIND_MEM;
        repeat (4) @(posedge mclk);
        #1 rst_n = 1;
        t_mem;
        t_io;
        t_epu_ack;
        t_quiet;
        t_stall;
        give_verdict;
    end
    initial #200000 hang("run time");
endmodule
